// File: inc/bio_pkg.sv
// package for the bidirectional io port block
// assumes a single 100 MHz clock and classic wishbone register access
package bio_pkg;

  // port widths: 8 + 8 + 7 = 23 lines on the largest variant
  localparam int PA_W = 8;
  localparam int PB_W = 8;
  localparam int PC_W = 7;

  // register word offsets (byte addresses)
  localparam logic [7:0] OFS_PORT_A   = 8'h00;
  localparam logic [7:0] OFS_DIR_A    = 8'h04;
  localparam logic [7:0] OFS_PORT_B   = 8'h08;
  localparam logic [7:0] OFS_DIR_B    = 8'h0C;
  localparam logic [7:0] OFS_PORT_C   = 8'h10;
  localparam logic [7:0] OFS_DIR_C    = 8'h14;
  localparam logic [7:0] OFS_WAKE_EN  = 8'h18;
  localparam logic [7:0] OFS_CTRL     = 8'h1C;
  localparam logic [7:0] OFS_STATUS   = 8'h20;
  localparam logic [7:0] OFS_MASK     = 8'h24;

  // reset values
  localparam logic [7:0]  RST_LATCH   = 8'hFF;
  localparam logic [7:0]  RST_DIR     = 8'hFF;
  localparam logic [7:0]  RST_WAKE_EN = 8'h00;
  localparam logic [1:0]  RST_MASK    = 2'h0;
  localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;

  // status / mask / ctrl bit positions
  localparam int ST_WAKE   = 0;
  localparam int ST_PA_CHG = 1;
  localparam int CTRL_HALT = 0;

  // core state
  typedef enum logic [0:0]
  {
    BIO_RUN  = 1'b0,
    BIO_HALT = 1'b1
  } bio_pwr_e;

  // wishbone request carrier
  typedef struct packed
  {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } bio_wb_req_s;

endpackage

// File: rtl/bio_port.sv
// one bidirectional port: output latch, direction register, read mux
// assumes the pins are already synchronised; pull-high and schmitt are options
module bio_port
  import bio_pkg::*;
#(
  parameter int         W       = 8,
  parameter logic       PULL_HI = 1'b0,
  parameter logic       SCHMITT = 1'b1
)
(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // register writes
  input  wire logic         wr_latch,
  input  wire logic         wr_dir,
  input  wire logic [W-1:0] wdata,
  // synchronised pin levels
  input  wire logic [W-1:0] pin_sync,
  // read side
  output logic      [W-1:0] port_rd,
  output logic      [W-1:0] dir_rd,
  // pin drive
  output logic      [W-1:0] pin_o,
  output logic      [W-1:0] pin_oe_n,
  output logic      [W-1:0] pull_en
);

  typedef struct packed
  {
    logic [W-1:0] latch;
    logic [W-1:0] dir;
    logic [W-1:0] inp;
  } bio_port_s;

  bio_port_s st_q;
  bio_port_s st_d;

  always_comb
  begin
    st_d = st_q;
    if (wr_latch)
      st_d.latch = wdata;
    if (wr_dir)
      st_d.dir = wdata;
    st_d.inp = pin_sync;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      // latches and directions reset to ones
      st_q.latch <= W'(RST_LATCH);
      st_q.dir   <= W'(RST_DIR);
      st_q.inp   <= '1;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      // pin or latch, schmitt one stage later
      assign port_rd[g]  = st_q.dir[g] ? (SCHMITT ? st_q.inp[g] : pin_sync[g]) : st_q.latch[g];
      // push-pull from latch when dir is zero
      assign pin_o[g]    = st_q.latch[g];
      assign pin_oe_n[g] = st_q.dir[g];
      // pull-high whole port, only on inputs
      assign pull_en[g]  = PULL_HI & st_q.dir[g];
    end
  endgenerate

  assign dir_rd = st_q.dir;

endmodule

// File: rtl/bio_sync.sv
// two-flop synchroniser for a vector of pin levels
// assumes pins are asynchronous to clk
module bio_sync
  import bio_pkg::*;
#(
  parameter int W = 8
)
(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // data
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  typedef struct packed
  {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } bio_sync_s;

  bio_sync_s st_q;
  bio_sync_s st_d;

  always_comb
  begin
    st_d.s1 = din;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      // idle pins read high
      st_q <= '1;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign dout = st_q.s2;

endmodule

// File: rtl/bio_top.sv
// bidirectional io ports with wishbone register access and port a wake-up
// assumes a classic wishbone master on clk; pins are asynchronous
// Operation
// - twenty-three two-way lines in three ports, each usable as input or output.
// - each port's data sits at its own fixed register address.
// - port input is not latched; a read returns the pin level after two synchroniser clocks, three on schmitt inputs.
// - written output data stays in its latch until written again.
// - input pins may get a weak pull-high chosen by a build option.
// - the pull-high option covers a whole port, never single pins.
// - in power-down the core stays idle until a selected port a pin falls.
// - each port a pin can be enabled for wake-up on its own.
// - each port has its own direction register with one bit per pin.
// - a one in a direction bit makes the pin an input reading the pin level.
// - a zero in a direction bit makes the pin a push-pull output from its latch.
// - reading an output pin returns the latch, not the pin level.
// - port a input type is a build option; other ports are always schmitt.
// - reset sets all latches and direction bits to ones.
// - bit set and clear are read-modify-write of the whole port.
//
// Implementation choices: the register offsets and the Wishbone slave port.
module bio_top
  import bio_pkg::*;
#(
  parameter logic PA_PULL_HI = 1'b0,
  parameter logic PB_PULL_HI = 1'b0,
  parameter logic PC_PULL_HI = 1'b0,
  parameter logic PA_SCHMITT = 1'b1
)
(
  // clock and reset
  input  wire logic            clk,
  input  wire logic            rst,
  // wishbone slave
  input  wire logic            wb_cyc_i,
  input  wire logic            wb_stb_i,
  input  wire logic            wb_we_i,
  input  wire logic [7:0]      wb_adr_i,
  input  wire logic [3:0]      wb_sel_i,
  input  wire logic [31:0]     wb_dat_i,
  output logic      [31:0]     wb_dat_o,
  output logic                 wb_ack_o,
  // port a pins
  input  wire logic [PA_W-1:0] port_a_i,
  output logic      [PA_W-1:0] port_a_o,
  output logic      [PA_W-1:0] port_a_oe_n,
  output logic      [PA_W-1:0] port_a_pull,
  // port b pins
  input  wire logic [PB_W-1:0] port_b_i,
  output logic      [PB_W-1:0] port_b_o,
  output logic      [PB_W-1:0] port_b_oe_n,
  output logic      [PB_W-1:0] port_b_pull,
  // port c pins
  input  wire logic [PC_W-1:0] port_c_i,
  output logic      [PC_W-1:0] port_c_o,
  output logic      [PC_W-1:0] port_c_oe_n,
  output logic      [PC_W-1:0] port_c_pull,
  // core power state
  output logic                 halted,
  output logic                 wake,
  output logic                 irq
);

  typedef struct packed
  {
    logic            ack;
    logic [31:0]     rdat;
    bio_pwr_e        pwr;
    logic            wake;
    logic [PA_W-1:0] wake_en;
    logic [PA_W-1:0] pa_prev;
    logic [1:0]      status;
    logic [1:0]      mask;
    logic            irq;
  } bio_top_s;

  bio_top_s    st_q;
  bio_top_s    st_d;
  bio_wb_req_s req;

  logic [PA_W-1:0] pa_sync;
  logic [PB_W-1:0] pb_sync;
  logic [PC_W-1:0] pc_sync;
  logic [PA_W-1:0] pa_rd;
  logic [PA_W-1:0] pa_dir;
  logic [PB_W-1:0] pb_rd;
  logic [PB_W-1:0] pb_dir;
  logic [PC_W-1:0] pc_rd;
  logic [PC_W-1:0] pc_dir;
  logic            wr_go;
  logic            rd_go;
  logic            lane0;
  logic [PA_W-1:0] pa_fall;
  logic            wake_hit;

  assign req.cyc = wb_cyc_i;
  assign req.stb = wb_stb_i;
  assign req.we  = wb_we_i;
  assign req.adr = wb_adr_i;
  assign req.sel = wb_sel_i;
  assign req.dat = wb_dat_i;

  // request accepted once; ack drops the cycle after
  assign wr_go = req.cyc & req.stb & req.we & ~st_q.ack;
  assign rd_go = req.cyc & req.stb & ~req.we & ~st_q.ack;
  assign lane0 = req.sel[0];

  // pins synchronised, never latched beyond that
  bio_sync #(.W(PA_W)) u_sync_a (.clk(clk), .rst(rst), .din(port_a_i), .dout(pa_sync));
  bio_sync #(.W(PB_W)) u_sync_b (.clk(clk), .rst(rst), .din(port_b_i), .dout(pb_sync));
  bio_sync #(.W(PC_W)) u_sync_c (.clk(clk), .rst(rst), .din(port_c_i), .dout(pc_sync));

  bio_port #(.W(PA_W), .PULL_HI(PA_PULL_HI), .SCHMITT(PA_SCHMITT)) u_port_a
  (
    .clk      (clk),
    .rst      (rst),
    .wr_latch (wr_go & lane0 & (req.adr == OFS_PORT_A)),
    .wr_dir   (wr_go & lane0 & (req.adr == OFS_DIR_A)),
    .wdata    (req.dat[PA_W-1:0]),
    .pin_sync (pa_sync),
    .port_rd  (pa_rd),
    .dir_rd   (pa_dir),
    .pin_o    (port_a_o),
    .pin_oe_n (port_a_oe_n),
    .pull_en  (port_a_pull)
  );

  bio_port #(.W(PB_W), .PULL_HI(PB_PULL_HI), .SCHMITT(1'b1)) u_port_b
  (
    .clk      (clk),
    .rst      (rst),
    .wr_latch (wr_go & lane0 & (req.adr == OFS_PORT_B)),
    .wr_dir   (wr_go & lane0 & (req.adr == OFS_DIR_B)),
    .wdata    (req.dat[PB_W-1:0]),
    .pin_sync (pb_sync),
    .port_rd  (pb_rd),
    .dir_rd   (pb_dir),
    .pin_o    (port_b_o),
    .pin_oe_n (port_b_oe_n),
    .pull_en  (port_b_pull)
  );

  bio_port #(.W(PC_W), .PULL_HI(PC_PULL_HI), .SCHMITT(1'b1)) u_port_c
  (
    .clk      (clk),
    .rst      (rst),
    .wr_latch (wr_go & lane0 & (req.adr == OFS_PORT_C)),
    .wr_dir   (wr_go & lane0 & (req.adr == OFS_DIR_C)),
    .wdata    (req.dat[PC_W-1:0]),
    .pin_sync (pc_sync),
    .port_rd  (pc_rd),
    .dir_rd   (pc_dir),
    .pin_o    (port_c_o),
    .pin_oe_n (port_c_oe_n),
    .pull_en  (port_c_pull)
  );

  // per-pin falling edge, only enabled pins
  assign pa_fall  = st_q.pa_prev & ~pa_sync & st_q.wake_en;
  // one combined request, only in power-down
  assign wake_hit = (st_q.pwr == BIO_HALT) & (|pa_fall);

  always_comb
  begin
    st_d         = st_q;
    st_d.ack     = rd_go | wr_go;
    st_d.pa_prev = pa_sync;
    st_d.wake    = 1'b0;
    st_d.rdat    = UNMAPPED_RD;
    // read returns whole port for read-modify-write
    if (rd_go)
    begin
      unique case (req.adr)
        OFS_PORT_A:  st_d.rdat = 32'(pa_rd);
        OFS_DIR_A:   st_d.rdat = 32'(pa_dir);
        OFS_PORT_B:  st_d.rdat = 32'(pb_rd);
        OFS_DIR_B:   st_d.rdat = 32'(pb_dir);
        OFS_PORT_C:  st_d.rdat = 32'(pc_rd);
        OFS_DIR_C:   st_d.rdat = 32'(pc_dir);
        OFS_WAKE_EN: st_d.rdat = 32'(st_q.wake_en);
        OFS_CTRL:    st_d.rdat = 32'(st_q.pwr == BIO_HALT);
        OFS_STATUS:  st_d.rdat = 32'(st_q.status);
        OFS_MASK:    st_d.rdat = 32'(st_q.mask);
        default:     st_d.rdat = UNMAPPED_RD;
      endcase
    end
    if (wr_go & lane0)
    begin
      if (req.adr == OFS_WAKE_EN)
        st_d.wake_en = req.dat[PA_W-1:0];
      if (req.adr == OFS_MASK)
        st_d.mask = req.dat[1:0];
      if (req.adr == OFS_CTRL && req.dat[CTRL_HALT])
        st_d.pwr = BIO_HALT;
    end
    // read of status clears; set below wins
    if (rd_go && req.adr == OFS_STATUS)
      st_d.status = 2'h0;
    // falling edge of selected pin ends power-down
    if (wake_hit)
    begin
      st_d.pwr            = BIO_RUN;
      st_d.wake           = 1'b1;
      st_d.status[ST_WAKE] = 1'b1;
    end
    if (|(st_q.pa_prev ^ pa_sync))
      st_d.status[ST_PA_CHG] = 1'b1;
    st_d.irq = |(st_d.status & st_d.mask);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_q         <= '0;
      st_q.pwr     <= BIO_RUN;
      st_q.pa_prev <= '1;
      st_q.wake_en <= RST_WAKE_EN;
      st_q.mask    <= RST_MASK;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign wb_ack_o = st_q.ack;
  assign wb_dat_o = st_q.rdat;
  assign halted   = (st_q.pwr == BIO_HALT);
  assign wake     = st_q.wake;
  assign irq      = st_q.irq;

  // assertions
  property p_ack_one;
    @(posedge clk) disable iff (rst)
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack held two cycles");

  property p_ack_after_req;
    @(posedge clk) disable iff (rst)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o;
  endproperty
  a_ack_after_req: assert property (p_ack_after_req) else $error("no ack after request");

  property p_rst_dir;
    @(posedge clk) $fell(rst) |-> (&port_a_oe_n) && (&port_a_o);
  endproperty
  a_rst_dir: assert property (p_rst_dir) else $error("port a not all ones after reset");

  property p_out_from_latch;
    @(posedge clk) disable iff (rst)
    (wr_go && lane0 && req.adr == OFS_PORT_A) |=> port_a_o == $past(wb_dat_i[PA_W-1:0]);
  endproperty
  a_out_from_latch: assert property (p_out_from_latch) else $error("latch not written");

  property p_latch_hold;
    @(posedge clk) disable iff (rst)
    !(wr_go && req.adr == OFS_PORT_B) |=> $stable(port_b_o);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("port b latch changed");

  property p_read_out_latch;
    @(posedge clk) disable iff (rst)
    (rd_go && req.adr == OFS_PORT_C && pc_dir == '0) |=> wb_dat_o[PC_W-1:0] == port_c_o;
  endproperty
  a_read_out_latch: assert property (p_read_out_latch) else $error("read not from latch");

  sequence s_halt_fall;
    halted ##0 (|pa_fall);
  endsequence

  property p_wake;
    @(posedge clk) disable iff (rst)
    s_halt_fall |=> wake && !halted;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on falling pin");

  property p_no_wake_disabled;
    @(posedge clk) disable iff (rst)
    (st_q.wake_en == '0) |=> !wake;
  endproperty
  a_no_wake_disabled: assert property (p_no_wake_disabled)
    else $error("wake while disabled");

  property p_wake_only_halt;
    @(posedge clk) disable iff (rst)
    !halted |=> !wake;
  endproperty
  a_wake_only_halt: assert property (p_wake_only_halt) else $error("wake while running");

  property p_irq;
    @(posedge clk) disable iff (rst)
    irq == |(st_q.status & st_q.mask);
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");

  property p_irq_wake;
    @(posedge clk) disable iff (rst)
    (wake && st_q.mask[ST_WAKE]) |-> irq;
  endproperty
  a_irq_wake: assert property (p_irq_wake) else $error("no irq on wake");

endmodule

// File: verif/bio_switch.sv
// model of switches and circuits hanging on one port's pins
// assumes dut drives pin when oe_n low; released pins float or pull up
module bio_switch
  import bio_pkg::*;
#(
  parameter int W = 8
)
(
  // clock
  input  wire logic         clk,
  // dut pin drive
  input  wire logic [W-1:0] o,
  input  wire logic [W-1:0] oe_n,
  input  wire logic [W-1:0] pull,
  // switch setting
  input  wire logic [W-1:0] sw,
  input  wire logic [W-1:0] sw_en,
  // resolved wire level
  output logic      [W-1:0] pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [W-1:0] flt_q = '0;
  // floating lines change every cycle
  always @(posedge clk)
    flt_q <= ~pin;
  always_comb
  begin
    for (int i = 0; i < W; i++)
    begin
      if (!oe_n[i])
        pin[i] = o[i];
      else if (sw_en[i])
        pin[i] = sw[i];
      else if (pull[i])
        pin[i] = 1'b1;
      else
        pin[i] = flt_q[i];
    end
  end
endmodule

// File: verif/testbench.sv
// register level tests of the io port block
// assumes one clock and switch models on every port
module testbench
  import bio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic            clk = 1'b0;
  logic            rst = 1'b1;
  bio_wb_req_s     req = '0;
  logic [31:0]     dat_o;
  logic            ack;
  logic [31:0]     rd;
  logic [PA_W-1:0] pa_o, pa_oe_n, pa_pu, pa_pin, sa, ea;
  logic [PB_W-1:0] pb_o, pb_oe_n, pb_pu, pb_pin, sb, eb;
  logic [PC_W-1:0] pc_o, pc_oe_n, pc_pu, pc_pin, sc, ec;
  logic            halted, wake, irq;
  int              err_total = 0;
  int              total_checks = 0;
  int              cyc_cnt = 0;
  int              wake_cnt = 0;
  initial
  begin
    sa = 8'hA5;
    sb = 8'h3C;
    sc = 7'h55;
    ea = '1;
    eb = '1;
    ec = '1;
  end
  always #5 clk = ~clk;
  bio_top #(.PA_PULL_HI(1'b1)) dut (
    .clk(clk), .rst(rst), .wb_cyc_i(req.cyc), .wb_stb_i(req.stb),
    .wb_we_i(req.we), .wb_adr_i(req.adr), .wb_sel_i(req.sel), .wb_dat_i(req.dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack),
    .port_a_i(pa_pin), .port_a_o(pa_o), .port_a_oe_n(pa_oe_n), .port_a_pull(pa_pu),
    .port_b_i(pb_pin), .port_b_o(pb_o), .port_b_oe_n(pb_oe_n), .port_b_pull(pb_pu),
    .port_c_i(pc_pin), .port_c_o(pc_o), .port_c_oe_n(pc_oe_n), .port_c_pull(pc_pu),
    .halted(halted), .wake(wake), .irq(irq));
  bio_switch #(.W(PA_W)) sw_a (.clk(clk), .o(pa_o), .oe_n(pa_oe_n), .pull(pa_pu),
    .sw(sa), .sw_en(ea), .pin(pa_pin));
  bio_switch #(.W(PB_W)) sw_b (.clk(clk), .o(pb_o), .oe_n(pb_oe_n), .pull(pb_pu),
    .sw(sb), .sw_en(eb), .pin(pb_pin));
  bio_switch #(.W(PC_W)) sw_c (.clk(clk), .o(pc_o), .oe_n(pc_oe_n), .pull(pc_pu),
    .sw(sc), .sw_en(ec), .pin(pc_pin));
  task automatic results();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // one classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{1'b1, 1'b1, w, a, s, d};
    do
    begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = dat_o;
    req <= '0;
    if (n == 20)
      chk(32'h1, 32'h0);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0, 4'hF);
    chk(rd, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'h1);
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask
  always @(posedge clk)
  begin
    cyc_cnt++;
    if (wake === 1'b1)
      wake_cnt++;
    if (cyc_cnt == 5000)
    begin
      err_total++;
      results();
    end
  end
  initial
  begin
    w(6);
    rst <= 1'b0;
    chk({pa_o, pb_o, pc_o}, 32'h7FFFFF);
    chk({pa_oe_n, pb_oe_n, pc_oe_n}, 32'h7FFFFF);
    chk({pa_pu, pb_pu, pc_pu}, 32'h7F8000);
    rdc(OFS_DIR_A, 32'hFF);
    rdc(OFS_DIR_C, 32'h7F);
    rdc(OFS_WAKE_EN, 32'h0);
    rdc(8'h30, UNMAPPED_RD);
    for (int i = 0; i < 2; i++)
    begin
      sa <= 8'hA5 ^ {8{i[0]}};
      sb <= 8'h3C ^ {8{i[0]}};
      sc <= 7'h55 ^ {7{i[0]}};
      w(5);
      rdc(OFS_PORT_A, 32'hA5 ^ {24'h0, {8{i[0]}}});
      rdc(OFS_PORT_B, 32'h3C ^ {24'h0, {8{i[0]}}});
      rdc(OFS_PORT_C, 32'h55 ^ {25'h0, {7{i[0]}}});
    end
    sb <= 8'h3C;
    w(1);
    rdc(OFS_PORT_B, 32'hC3);
    rdc(OFS_PORT_B, 32'h3C);
    ea <= '0;
    w(5);
    rdc(OFS_PORT_A, 32'hFF);
    ea <= '1;
    sa <= 8'hA5;
    $display("test reset and input done");
    wr(OFS_PORT_A, 32'h33);
    wr(OFS_DIR_A, 32'h0F);
    w(5);
    rdc(OFS_PORT_A, 32'h35);
    chk(pa_oe_n, 32'h0F);
    chk(pa_pin[7:4], 32'h3);
    wb(1'b1, OFS_PORT_A, 32'hFF, 4'h0);
    chk(pa_o, 32'h33);
    wr(OFS_DIR_B, 32'h0);
    wr(OFS_PORT_B, 32'hC3);
    rdc(OFS_PORT_B, 32'hC3);
    rdc(OFS_DIR_A, 32'h0F);
    wr(OFS_PORT_C, 32'h2A);
    wr(OFS_DIR_C, 32'h0);
    rdc(OFS_PORT_C, 32'h2A);
    wb(1'b0, OFS_PORT_A, 32'h0, 4'hF);
    wr(OFS_PORT_A, rd | 32'h40);
    chk(pa_o, 32'h75);
    wr(OFS_DIR_A, 32'hFF);
    $display("test output done");
    sa <= 8'hFF;
    wr(OFS_WAKE_EN, 32'h01);
    wr(OFS_MASK, 32'h01);
    w(5);
    wb(1'b0, OFS_STATUS, 32'h0, 4'hF);
    wake_cnt = 0;
    sa <= 8'hFE;
    w(8);
    chk(wake_cnt, 32'h0);
    sa <= 8'hFF;
    wr(OFS_CTRL, 32'h01);
    w(2);
    chk(halted, 32'h1);
    rdc(OFS_CTRL, 32'h1);
    sa <= 8'hFD;
    w(8);
    chk({halted, wake_cnt[0]}, 32'h2);
    sa <= 8'hFC;
    w(8);
    chk({halted, irq, wake_cnt[1:0]}, 32'h5);
    wb(1'b0, OFS_STATUS, 32'h0, 4'hF);
    chk(rd, 32'h3);
    w(2);
    chk(irq, 32'h0);
    wb(1'b0, OFS_STATUS, 32'h0, 4'hF);
    chk(rd, 32'h0);
    $display("test wake done");
    results();
  end
endmodule
